/* File: hdl/crpm_top.sv */
/*
  Clock, reset and power-mode control. Clocks are modelled as one-cycle
  enable ticks on the 10 MHz system clock; the two output pins carry
  divided square waves.
  Assumes the reference ticks arrive synchronous to clk, at most one per
  cycle, and that the slow-crystal tick is absent when no crystal is fitted.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: Slow clock comes from the 32.768 kHz crystal when fitted.
// RULE2: Without that crystal, slow clock is a prescaled high-speed clock.
// RULE3: Two independent divided high-speed clocks drive output pins.
// RULE4: PLL multiplies the 12 MHz reference up to 24 MHz.
// RULE5: Fixed-rate module clocks are prescaled from 12 MHz, not the PLL.
// RULE6: PLL output is the USB node input clock.
// RULE7: High-speed clock is PLL via prescaler or 12 MHz reference directly.
// RULE8: Device reset combines external reset and on-chip reset requests.
// RULE9: Power-on reset asserts system reset without external input.
// RULE10: Active mode clocks everything from the high-speed clock.
// RULE11: Power Save runs CPU and some modules from the slow clock.
// RULE12: Idle keeps only the mode manager and watchdog unit on slow clock.
// RULE13: Halt stops all clocks while state is kept. clk_out0 and clk_out1 keep toggling in Halt while the high-speed clock is the reference.
// RULE14: The timing and watchdog unit runs on the slow clock.
// RULE15: A watchdog trigger resets the whole device.
// RULE16: Real-time timer output is one of the 16 wake-up inputs.
// RULE17: After reset, Active mode with high-speed clock from the reference.
// RULE18: Clock source switching is glitch-free.
module crpm_top #(
  parameter int DIV_W = crpm_pkg::DIV_W,
  parameter int NWAKE = crpm_pkg::WAKE_INPUTS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Reference ticks
  input wire logic main_ref_tick,
  input wire logic slow_xtal_tick,
  input wire logic slow_xtal_fitted,
  // Configuration
  input wire crpm_pkg::crpm_cfg_type cfg,
  // Mode requests
  input wire logic mode_req,
  input wire crpm_pkg::crpm_mode_type mode_sel,
  input wire logic [NWAKE-1:0] wake_in,
  input wire logic [NWAKE-1:0] wake_en,
  // Reset sources
  input wire logic ext_reset_n,
  input wire logic [3:0] module_reset_req,
  input wire logic watchdog_trigger,
  // Generated clocks
  output logic pll_tick,
  output logic usb_clk_tick,
  output logic hs_tick,
  output logic slow_tick,
  output logic fixed_tick,
  output logic clk_out0,
  output logic clk_out1,
  output logic hs_source_pll,
  output logic slow_source_xtal,
  // Gated clocks and mode
  output crpm_pkg::crpm_en_type clk_en,
  output crpm_pkg::crpm_mode_type mode,
  output logic rt_timer_out,
  // Reset
  output logic sys_reset_n,
  output logic por_active
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [7:0] por_cnt;
    logic por_done;
    logic [1:0] rst_sync;
    logic [1:0] pll_phase;
    logic pll_tick;
    logic hs_pll_sel;
    logic slow_xtal_sel;
    logic hs_pending;
    logic slow_pending;
    crpm_pkg::crpm_mode_type mode;
    crpm_pkg::crpm_en_type en;
    logic [3:0] rt_cnt;
    logic rt_out;
    logic [NWAKE-1:0] wake_prev;
  } crpm_state_type;

  crpm_state_type state;
  crpm_state_type next_state;

  logic hs_pll_tick;
  logic hs_src_tick;
  logic slow_pre_tick;
  logic slow_tick_int;
  logic wake_edge;
  logic [NWAKE-1:0] wake_vec;
  logic reset_req;

  // ==========================================================
  // Dividers
  // ==========================================================
  crpm_div #(.W(DIV_W)) u_hs_div (
    .clk(clk),
    .rst_n(rst_n),
    .in_tick(state.pll_tick),
    .div(cfg.hs_div),
    .tick(hs_pll_tick),
    .wave()
  ); // RULE7

  // High-speed clock is either prescaled PLL or the raw reference.
  assign hs_src_tick = state.hs_pll_sel ? hs_pll_tick : main_ref_tick; // RULE7

  crpm_div #(.W(DIV_W)) u_slow_div (
    .clk(clk),
    .rst_n(rst_n),
    .in_tick(hs_src_tick),
    .div(cfg.slow_div),
    .tick(slow_pre_tick),
    .wave()
  ); // RULE2

  assign slow_tick_int = state.slow_xtal_sel ? slow_xtal_tick :
      slow_pre_tick; // RULE1

  crpm_div #(.W(DIV_W)) u_out0_div (
    .clk(clk),
    .rst_n(rst_n),
    .in_tick(hs_src_tick),
    .div(cfg.out0_div),
    .tick(),
    .wave(clk_out0)
  ); // RULE3

  crpm_div #(.W(DIV_W)) u_out1_div (
    .clk(clk),
    .rst_n(rst_n),
    .in_tick(hs_src_tick),
    .div(cfg.out1_div),
    .tick(),
    .wave(clk_out1)
  ); // RULE3

  // Fixed-rate clock is taken from the reference so it never moves with
  // the PLL or the high-speed selection.
  crpm_div #(.W(DIV_W)) u_fixed_div (
    .clk(clk),
    .rst_n(rst_n),
    .in_tick(main_ref_tick & state.en.fixed),
    .div(cfg.fixed_div),
    .tick(fixed_tick),
    .wave()
  ); // RULE5

  // ==========================================================
  // Wake and reset sources
  // ==========================================================
  assign wake_vec = {wake_in[NWAKE-1:1], state.rt_out}; // RULE16
  assign wake_edge = |(wake_vec & ~state.wake_prev & wake_en);
  assign reset_req = ~ext_reset_n | (|module_reset_req) |
      watchdog_trigger; // RULE8 RULE15

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    next_state = state;
    next_state.pll_tick = 1'b0;
    next_state.wake_prev = wake_vec;
    // Power-on counter needs no external pin to hold reset.
    if (!state.por_done) begin
      if (state.por_cnt >= crpm_pkg::POR_COUNT) begin
        next_state.por_done = 1'b1; // RULE9
      end else begin
        next_state.por_cnt = state.por_cnt + 8'h01; // RULE9
      end
    end
    next_state.rst_sync = {state.rst_sync[0],
        state.por_done & ~reset_req}; // RULE8
    // Two PLL ticks per reference tick: 12 MHz in, 24 MHz out. A reference
    // tick that lands during a running burst adds to it, capped at 3; overwriting the
    // count there would drop half of the output ticks.
    if (state.pll_phase != 2'h0) begin
      next_state.pll_phase = state.pll_phase - 2'h1;
      next_state.pll_tick = 1'b1; // RULE4
    end
    if (main_ref_tick && state.en.usb) begin
      next_state.pll_phase = (next_state.pll_phase > 2'h1) ? 2'h3 :
          next_state.pll_phase + crpm_pkg::PLL_MULT; // RULE4
    end
    // Source changes wait for an edge of the new source so that no
    // shortened pulse leaks; a late tick costs at most one period.
    if (cfg.hs_use_pll != state.hs_pll_sel) begin
      next_state.hs_pending = 1'b1;
    end
    if (state.hs_pending && (cfg.hs_use_pll ? hs_pll_tick :
        main_ref_tick)) begin
      next_state.hs_pll_sel = cfg.hs_use_pll; // RULE18
      next_state.hs_pending = 1'b0;
    end
    if ((cfg.slow_use_xtal & slow_xtal_fitted) != state.slow_xtal_sel) begin
      next_state.slow_pending = 1'b1;
    end
    if (state.slow_pending && ((cfg.slow_use_xtal & slow_xtal_fitted) ?
        slow_xtal_tick : slow_pre_tick)) begin
      next_state.slow_xtal_sel = cfg.slow_use_xtal & slow_xtal_fitted; // RULE18
      next_state.slow_pending = 1'b0;
    end
    // Real-time timer runs from the slow clock.
    if (slow_tick_int && state.en.timing_watchdog_unit) begin // RULE14
      if (state.rt_cnt == crpm_pkg::RT_TICK_SLOW) begin
        next_state.rt_cnt = 4'h0;
        next_state.rt_out = ~state.rt_out;
      end else begin
        next_state.rt_cnt = state.rt_cnt + 4'h1;
      end
    end
    // Mode changes.
    if (mode_req) begin
      next_state.mode = mode_sel;
    end else if (wake_edge && state.mode != crpm_pkg::CRPM_ACTIVE) begin
      next_state.mode = crpm_pkg::CRPM_ACTIVE;
    end
    case (next_state.mode)
      crpm_pkg::CRPM_ACTIVE: begin
        next_state.en = '1; // RULE10
      end
      crpm_pkg::CRPM_POWER_SAVE: begin
        next_state.en = '1;
        next_state.en.usb = 1'b0; // RULE11
        next_state.en.fixed = 1'b0;
      end
      crpm_pkg::CRPM_IDLE: begin
        next_state.en = '0;
        next_state.en.power_mode_manager = 1'b1; // RULE12
        next_state.en.timing_watchdog_unit = 1'b1;
      end
      default: begin
        next_state.en = '0; // RULE13
      end
    endcase
    if (state.rst_sync[1] == 1'b0) begin
      next_state.mode = crpm_pkg::CRPM_ACTIVE; // RULE17
      next_state.en = '1;
      next_state.hs_pll_sel = 1'b0; // RULE17
      next_state.hs_pending = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.mode <= crpm_pkg::CRPM_ACTIVE;
      state.en <= '1;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign pll_tick = state.pll_tick;
  assign usb_clk_tick = state.pll_tick; // RULE6
  // Power Save rate follows the slow clock; Idle and Halt give no hs ticks.
  assign hs_tick = (state.mode == crpm_pkg::CRPM_ACTIVE) ? hs_src_tick :
      ((state.mode == crpm_pkg::CRPM_POWER_SAVE) ? slow_tick_int : 1'b0); // RULE11
  assign slow_tick = (state.mode == crpm_pkg::CRPM_HALT) ? 1'b0 :
      slow_tick_int; // RULE13
  assign hs_source_pll = state.hs_pll_sel;
  assign slow_source_xtal = state.slow_xtal_sel;
  assign clk_en = state.en;
  assign mode = state.mode;
  assign rt_timer_out = state.rt_out;
  assign sys_reset_n = state.rst_sync[1];
  assign por_active = ~state.por_done;

endmodule
`default_nettype wire

/* File: hdl/crpm_pkg.sv */
/*
  Package for the clock, reset and power-mode block: shared constants,
  mode encodings and the packed carriers used between the files.
  Assumes a single 10 MHz system clock drives all of the logic.
*/
package crpm_pkg;

  // ==========================================================
  // Clock figures
  // ==========================================================
  localparam int CLK_HZ = 10000000;
  localparam int SLOW_HZ = 32768;
  localparam int MAIN_REF_HZ = 12000000;
  localparam int PLL_MAX_HZ = 24000000;
  localparam int WAKE_INPUTS = 16;

  // ==========================================================
  // Reset and divider constants
  // ==========================================================
  localparam int POR_TIME_NS = 1000;
  localparam int POR_CYCLES = (POR_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [7:0] POR_COUNT = 8'(POR_CYCLES);
  localparam int DIV_W = 8;
  localparam logic [7:0] SLOW_DIV_RESET = 8'hFF;
  localparam logic [7:0] HS_DIV_RESET = 8'h01;
  localparam logic [7:0] OUT_DIV_RESET = 8'h04;
  localparam logic [7:0] FIXED_DIV_RESET = 8'h06;
  localparam logic [1:0] PLL_MULT = 2'h2;
  localparam logic [3:0] RT_TICK_SLOW = 4'hF;

  // ==========================================================
  // Power modes
  // ==========================================================
  typedef enum logic [1:0] {
    CRPM_ACTIVE,
    CRPM_POWER_SAVE,
    CRPM_IDLE,
    CRPM_HALT
  } crpm_mode_type;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic [7:0] slow_div;
    logic [7:0] hs_div;
    logic [7:0] out0_div;
    logic [7:0] out1_div;
    logic [7:0] fixed_div;
    logic hs_use_pll;
    logic slow_use_xtal;
  } crpm_cfg_type;

  typedef struct packed {
    logic cpu;
    logic periph;
    logic usb;
    logic fixed;
    logic power_mode_manager;
    logic timing_watchdog_unit;
  } crpm_en_type;

endpackage

/* File: hdl/crpm_div.sv */
/*
  Programmable enable divider: emits one-cycle ticks every div+1 input
  ticks and a square wave toggled at each output tick.
  Assumes div is held stable by its owner; a change takes effect at the next input tick.
*/
`timescale 1ns/1ps
`default_nettype none
module crpm_div #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic in_tick,
  input wire logic [W-1:0] div,
  // Result
  output logic tick,
  output logic wave
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
    logic wave;
  } crpm_div_state_type;

  crpm_div_state_type state;
  crpm_div_state_type next_state;

  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (in_tick) begin
      if (state.cnt >= div) begin
        next_state.cnt = '0;
        next_state.tick = 1'b1;
        next_state.wave = ~state.wave;
      end else begin
        next_state.cnt = state.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;
  assign wave = state.wave;

endmodule
`default_nettype wire

/* File: verif/crpm_ref_model.sv */
/* Far-side model: reference and slow crystal networks as tick sources.
   Assumes clk is the 10 MHz system clock of the bench. */
`timescale 1ns/1ps
`default_nettype none
module crpm_ref_model #(
  parameter int REF_GAP = 2,
  parameter int SLOW_GAP = 305
) (
  // Clock
  input wire logic clk,
  // Crystal present
  input wire logic fit,
  // Ticks
  output logic main_ref_tick,
  output logic slow_xtal_tick,
  output logic slow_xtal_fitted
);
  int rc = 0;
  int sc = 0;
  always @(posedge clk) begin
    rc <= (rc + 1) % REF_GAP;
    sc <= (sc + 1) % SLOW_GAP;
  end
  assign main_ref_tick = (rc == 0);
  // An absent crystal gives no ticks at all, not a stale level.
  assign slow_xtal_tick = fit && (sc == 0);
  assign slow_xtal_fitted = fit;
endmodule
`default_nettype wire

/* File: verif/crpm_top_checker.sv */
/* Port assertions for crpm_top.
   Assumes the bind below attaches it to every crpm_top. */
`timescale 1ns/1ps
`default_nettype none
module crpm_top_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Inputs
  input wire logic mode_req,
  input wire crpm_pkg::crpm_mode_type mode_sel,
  input wire logic ext_reset_n,
  input wire logic [3:0] module_reset_req,
  input wire logic watchdog_trigger,
  // Outputs
  input wire logic pll_tick,
  input wire logic usb_clk_tick,
  input wire crpm_pkg::crpm_en_type clk_en,
  input wire crpm_pkg::crpm_mode_type mode,
  input wire logic sys_reset_n,
  input wire logic por_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ======================================================
  // Sequences
  sequence req_taken;
    mode_req && sys_reset_n;
  endsequence
  sequence src_seen;
    !ext_reset_n || (|module_reset_req);
  endsequence
  // ======================================================
  // Properties
  mode_load_a: assert property (req_taken |=> mode == $past(mode_sel))
    else $error("mode did not follow request");
  save_clocks_a: assert property (mode == crpm_pkg::CRPM_POWER_SAVE |->
    clk_en.cpu && !clk_en.usb && !clk_en.fixed)
    else $error("power save enables wrong");
  idle_clocks_a: assert property (mode == crpm_pkg::CRPM_IDLE |->
    clk_en == 6'h03) else $error("idle enables wrong");
  halt_clocks_a: assert property (mode == crpm_pkg::CRPM_HALT |->
    clk_en == 6'h00) else $error("halt enables wrong");
  reset_src_a: assert property (src_seen |-> ##2 !sys_reset_n)
    else $error("reset source ignored");
  wdog_reset_a: assert property (watchdog_trigger |-> ##2 !sys_reset_n)
    else $error("watchdog did not reset");
  por_hold_a: assert property (por_active |-> !sys_reset_n)
    else $error("reset released during power-on");
  usb_pll_a: assert property (usb_clk_tick |-> pll_tick)
    else $error("usb tick without pll tick");
endmodule
bind crpm_top crpm_top_checker crpm_top_checker_inst (.clk, .rst_n,
  .mode_req, .mode_sel, .ext_reset_n, .module_reset_req,
  .watchdog_trigger, .pll_tick, .usb_clk_tick, .clk_en, .mode,
  .sys_reset_n, .por_active);
`default_nettype wire

/* File: verif/clock_reset_power_modes_tb.sv */
/* Self-checking bench for crpm_top.
   Assumes crpm_ref_model supplies the reference ticks. */
`timescale 1ns/1ps
`default_nettype none
module clock_reset_power_modes_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fit = 1'b1;
  logic main_ref_tick, slow_xtal_tick, slow_xtal_fitted;
  crpm_pkg::crpm_cfg_type cfg;
  logic mode_req = 1'b0;
  crpm_pkg::crpm_mode_type mode_sel = crpm_pkg::CRPM_ACTIVE;
  logic [15:0] wake_in = 16'h0000;
  logic [15:0] wake_en = 16'h0000;
  logic ext_reset_n = 1'b1;
  logic [3:0] module_reset_req = 4'h0;
  logic watchdog_trigger = 1'b0;
  logic pll_tick, usb_clk_tick, hs_tick, slow_tick, fixed_tick;
  logic clk_out0, clk_out1, hs_source_pll, slow_source_xtal;
  logic rt_timer_out, sys_reset_n, por_active;
  crpm_pkg::crpm_en_type clk_en;
  crpm_pkg::crpm_mode_type mode;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  crpm_ref_model crpm_ref_model_inst (.clk, .fit, .main_ref_tick,
    .slow_xtal_tick, .slow_xtal_fitted);
  crpm_top crpm_top_inst (.clk, .rst_n, .main_ref_tick, .slow_xtal_tick,
    .slow_xtal_fitted, .cfg, .mode_req, .mode_sel, .wake_in, .wake_en,
    .ext_reset_n, .module_reset_req, .watchdog_trigger, .pll_tick,
    .usb_clk_tick, .hs_tick, .slow_tick, .fixed_tick, .clk_out0,
    .clk_out1, .hs_source_pll, .slow_source_xtal, .clk_en, .mode,
    .rt_timer_out, .sys_reset_n, .por_active);
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic req(crpm_pkg::crpm_mode_type m);
    @(posedge clk) mode_req <= 1'b1;
    mode_sel <= m;
    @(posedge clk) mode_req <= 1'b0;
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ======================================================
  // Scenarios
  task automatic t_por();
    int i;
    chk("por_active", 1, por_active);
    for (i = 0; i < 40 && sys_reset_n !== 1'b1; i++) #100;
    chk("por length", 1, i >= 10);
    chk("mode", crpm_pkg::CRPM_ACTIVE, mode);
    chk("clk_en", 6'h3F, clk_en);
    chk("hs source", 0, hs_source_pll);
  endtask
  task automatic t_modes();
    logic [5:0] msk, ex;
    int k, i;
    for (k = 1; k < 4; k++) begin
      // Peripheral enable in power save is left to the design.
      msk = (k == 1) ? 6'h2F : 6'h3F;
      ex = (k == 1) ? 6'h23 : (k == 2) ? 6'h03 : 6'h00;
      req(crpm_pkg::crpm_mode_type'(k));
      chk("mode", k, mode);
      chk("clk_en", ex, clk_en & msk);
      @(posedge clk) wake_en <= 16'h0002;
      wake_in <= 16'h0002;
      #1;
      for (i = 0; i < 4 && mode !== crpm_pkg::CRPM_ACTIVE; i++) #100;
      chk("woken", crpm_pkg::CRPM_ACTIVE, mode);
      @(posedge clk) wake_en <= 16'h0000;
      wake_in <= 16'h0000;
    end
  endtask
  task automatic t_rt_wake();
    int i;
    req(crpm_pkg::CRPM_IDLE);
    @(posedge clk) wake_en <= 16'h0001;
    #1;
    for (i = 0; i < 12000 && mode !== crpm_pkg::CRPM_ACTIVE; i++) #100;
    chk("rt wake", crpm_pkg::CRPM_ACTIVE, mode);
    @(posedge clk) wake_en <= 16'h0000;
  endtask
  task automatic t_resets();
    int k, i;
    for (k = 0; k < 3; k++) begin
      req(crpm_pkg::CRPM_IDLE);
      @(posedge clk) ext_reset_n <= (k != 0);
      module_reset_req <= (k == 1) ? 4'h8 : 4'h0;
      watchdog_trigger <= (k == 2);
      @(posedge clk) ext_reset_n <= 1'b1;
      module_reset_req <= 4'h0;
      watchdog_trigger <= 1'b0;
      @(posedge clk);
      #1;
      chk("sys_reset_n", 0, sys_reset_n);
      for (i = 0; i < 40 && sys_reset_n !== 1'b1; i++) #100;
      chk("mode", crpm_pkg::CRPM_ACTIVE, mode);
    end
  endtask
  task automatic t_clocks();
    int n[8];
    logic p0, p1;
    int i;
    n = '{0, 0, 0, 0, 0, 0, 0, 0};
    for (i = 0; i < 400; i++) begin
      p0 = clk_out0;
      p1 = clk_out1;
      #100;
      n[0] += pll_tick;
      n[1] += usb_clk_tick;
      n[2] += (clk_out0 != p0);
      n[3] += (clk_out1 != p1);
      n[4] += fixed_tick;
      n[5] += main_ref_tick;
      n[6] += hs_tick;
      n[7] += slow_tick;
    end
    chk("usb ticks", n[0], n[1]);
    chk("pll runs", 1, n[0] > 0);
    chk("pll double", 1, n[0] >= 2 * n[5] - 2 && n[0] <= 2 * n[5] + 2);
    chk("hs runs", 1, n[6] > 0);
    chk("slow runs", 1, n[7] > 0);
    chk("out0 faster", 1, n[2] > n[3] && n[3] > 0);
    chk("fixed runs", 1, n[4] > 0);
    @(posedge clk) cfg.hs_use_pll <= 1'b1;
    #1;
    for (i = 0; i < 50 && hs_source_pll !== 1'b1; i++) #100;
    chk("hs on pll", 1, hs_source_pll);
    chk("xtal used", 1, slow_source_xtal);
    @(posedge clk) fit <= 1'b0;
    #1;
    for (i = 0; i < 3000 && slow_source_xtal !== 1'b0; i++) #100;
    chk("xtal dropped", 0, slow_source_xtal);
  endtask
  // ======================================================
  // Sequence and watchdog of the run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    cfg = {8'h03, 8'h01, 8'h01, 8'h03, 8'h05, 1'b0, 1'b1};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_por();
    t_modes();
    t_rt_wake();
    t_resets();
    t_clocks();
    close_out();
  end
endmodule
`default_nettype wire
